// ### core/cmc_pkg.sv
// Package with constants and carrier types for the cipher module control block
package cmc_pkg;

    // Clock rate and tone timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TONE_HZ = 750;
    localparam int unsigned BURST_MS = 87;
    // Half period of the 750 Hz square wave, in cycles (rounded down)
    localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    // One 87 ms burst or gap, in cycles (exact at 50 MHz, no rounding)
    localparam int unsigned BURST_CYC = (CLK_HZ / 1000) * BURST_MS;
    localparam int unsigned CNT_W = 23;

    // Module group and position counts
    localparam int unsigned GROUP_SIZE = 4;
    localparam int unsigned MODULE_COUNT = 8;

    // Reset value of the function-select output
    localparam logic FUNC_SEL_RESET = 1'b0;

    // Alert enable bit positions
    localparam int unsigned AL_CLEAR_TX = 0;
    localparam int unsigned AL_CLEAR_RX = 1;
    localparam int unsigned AL_CROSS = 2;
    localparam int unsigned AL_ERASE = 3;
    localparam int unsigned AL_TX_FAIL = 4;
    localparam int unsigned AL_RX_FAIL = 5;
    localparam int unsigned AL_COUNT = 6;

    // Firmware selection word received over the ring link
    typedef struct packed {
        logic full_duplex;
        logic [3:0] key_digit;
        logic func_sel;
    } cmc_select_type;

    // Station activity levels
    typedef struct packed {
        logic ptt_clear;
        logic ptt_coded;
        logic rx_clear;
        logic rx_coded;
        logic wireline_coded;
    } cmc_activity_type;

    // Tone sequencer states
    typedef enum logic [2:0] {
        TS_IDLE = 3'b001,
        TS_ON = 3'b010,
        TS_OFF = 3'b100
    } cmc_tone_state_type;

endpackage

// ### core/cmc_top.sv
// Cipher module control: group lines, key selection, alert tones, key loading
`timescale 1ns/1ps

// Operation
// RULE1 - Each four-module group has its own shared lines
// RULE2 - Full duplex: first group encrypts, second decrypts
// RULE3 - Mode line low encrypts, high decrypts
// RULE4 - Control high encrypting, low for decrypt or end pattern
// RULE5 - Function select defaults low; picks range mode
// RULE6 - Function select picks stored or derived key
// RULE7 - Half duplex: digits 1-4 group one, 5-8 two
// RULE8 - Full duplex: digits n, n+4 pick pair n
// RULE9 - Selection comes from firmware over ring link
// RULE10 - Alert tones are 750 Hz, six enables, no transmitter
// RULE11 - Clear transmit start gives one 87 ms burst
// RULE12 - Clear receive start gives one 87 ms burst
// RULE13 - Cross-mode burst on clear receive when wireline coded
// RULE14 - Continuous tone while key erase is active
// RULE15 - Coded transmit with lost key pulses 87/87 ms
// RULE16 - Coded receive with lost key pulses 87/87 ms
// RULE17 - Key lines of every module are monitored; the code checks only the enc_index and dec_index key lines
// RULE18 - Grounded loader-present line forces access disable
// RULE19 - Key loading always uses the half-duplex mapping
// RULE20 - Any of eight positions selectable for loading
// RULE21 - Loader signals reach only the selected module
// RULE22 - Write enable low while writing; clock follows data
module cmc_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire cmc_pkg::cmc_select_type ring_select,
    input wire logic end_of_message_req,
    input wire cmc_pkg::cmc_activity_type activity,
    input wire logic [cmc_pkg::AL_COUNT-1:0] alert_enable,
    input wire logic [cmc_pkg::MODULE_COUNT-1:0] module_key_n,
    input wire logic loader_present_ground,
    input wire logic key_write_enable,
    input wire logic key_insert_serial_data,
    input wire logic key_transfer_line_in,
    input wire logic [cmc_pkg::MODULE_COUNT-1:0] module_key_in,
    input wire logic external_erase_request_n,
    input wire logic fw_erase_request,
    output logic group_a_mode,
    output logic group_a_control,
    output logic group_b_mode,
    output logic group_b_control,
    output logic func_select,
    output logic [cmc_pkg::MODULE_COUNT-1:0] module_write_enable_n,
    output logic [cmc_pkg::MODULE_COUNT-1:0] module_key_data,
    output logic [cmc_pkg::MODULE_COUNT-1:0] module_key_oe,
    output logic [cmc_pkg::MODULE_COUNT-1:0] module_load_clk,
    output logic key_transfer_line_out,
    output logic key_transfer_line_oe,
    output logic key_erase_n,
    output logic access_disable,
    output logic [2:0] enc_index,
    output logic [2:0] dec_index,
    output logic tx_key_fail,
    output logic rx_key_fail,
    output logic alert_tone,
    output logic tone_to_transmitter
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for pins from outside the clock domain

    // Two-stage synchronisers; stage one feeds only stage two
    logic [cmc_pkg::MODULE_COUNT-1:0] key_n_s1_q, key_n_s2_q;
    logic [cmc_pkg::MODULE_COUNT-1:0] mkey_s1_q, mkey_s2_q;
    logic [4:0] pin_s1_q, pin_s2_q;

    // Sync all pins; reset to each pin's idle level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            key_n_s1_q <= 8'hFF;
            key_n_s2_q <= 8'hFF;
            mkey_s1_q <= 8'h00;
            mkey_s2_q <= 8'h00;
            pin_s1_q <= 5'h1B;
            pin_s2_q <= 5'h1B;
        end else begin
            key_n_s1_q <= module_key_n;
            key_n_s2_q <= key_n_s1_q;
            mkey_s1_q <= module_key_in;
            mkey_s2_q <= mkey_s1_q;
            pin_s1_q <= {loader_present_ground, key_write_enable, key_insert_serial_data,
                         key_transfer_line_in, external_erase_request_n};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Synchronised pin levels
    logic loader_gnd_s, we_s, kid_s, xfer_in_s, ext_erase_n_s;
    assign loader_gnd_s = pin_s2_q[4];
    assign we_s = pin_s2_q[3];
    assign kid_s = pin_s2_q[2];
    assign xfer_in_s = pin_s2_q[1];
    assign ext_erase_n_s = pin_s2_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Key digit to module mapping

    // Loader present means access disable
    logic loading;
    assign loading = !loader_gnd_s; // RULE18

    // Digits 1..8 to positions 0..7; others clamp to digit 1
    logic [2:0] digit_pos;
    always_comb begin
        if (ring_select.key_digit >= 4'h1 && ring_select.key_digit <= 4'h8) begin
            digit_pos = 3'(ring_select.key_digit - 4'h1); // RULE9 RULE20
        end else begin
            digit_pos = 3'h0;
        end
    end

    // Full duplex pairs positions n and n+4; loading ignores duplex mode
    logic fdx_eff;
    assign fdx_eff = ring_select.full_duplex && !loading; // RULE19

    logic [2:0] enc_d, dec_d;
    always_comb begin
        if (fdx_eff) begin
            enc_d = {1'b0, digit_pos[1:0]}; // RULE8
            dec_d = {1'b1, digit_pos[1:0]}; // RULE8
        end else begin
            enc_d = digit_pos; // RULE7
            dec_d = digit_pos; // RULE7
        end
    end

    // Selected indices, registered for the outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            enc_index <= 3'h0;
            dec_index <= 3'h0;
        end else begin
            enc_index <= enc_d;
            dec_index <= dec_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Group mode and control lines

    // Half duplex: only the group in use encrypts, during transmit
    logic ptt_any;
    assign ptt_any = activity.ptt_clear || activity.ptt_coded;

    logic a_dec, b_dec;
    always_comb begin
        if (fdx_eff) begin
            a_dec = 1'b0; // RULE2
            b_dec = 1'b1; // RULE2
        end else begin
            // Idle group rests in decrypt so it cannot emit cipher data
            a_dec = !(ptt_any && !digit_pos[2]);
            b_dec = !(ptt_any && digit_pos[2]);
        end
    end

    // Each group drives its own pair of shared lines
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            group_a_mode <= 1'b1;
            group_a_control <= 1'b0;
            group_b_mode <= 1'b1;
            group_b_control <= 1'b0;
        end else begin
            group_a_mode <= a_dec; // RULE1 RULE3
            group_b_mode <= b_dec; // RULE1 RULE3
            // Control: high to encrypt, low to decrypt or request the end pattern
            group_a_control <= !a_dec && !end_of_message_req; // RULE4
            group_b_control <= !b_dec && !end_of_message_req; // RULE4
        end
    end

    // Shared function select, low by default; meaning is per module type
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            func_select <= cmc_pkg::FUNC_SEL_RESET; // RULE5
        end else begin
            func_select <= ring_select.func_sel; // RULE5 RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Key-fail monitor and key erase

    // Only the enc_index and dec_index key lines are watched; they raise the flags
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_key_fail <= 1'b0;
            rx_key_fail <= 1'b0;
        end else begin
            tx_key_fail <= !key_n_s2_q[enc_index]; // RULE17
            rx_key_fail <= !key_n_s2_q[dec_index]; // RULE17
        end
    end

    // Erase from the pin or from firmware; low active to all modules
    logic erase_active;
    assign erase_active = !ext_erase_n_s || fw_erase_request;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            key_erase_n <= 1'b1;
            access_disable <= 1'b0;
        end else begin
            key_erase_n <= !erase_active;
            access_disable <= loading; // RULE18
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Key loader routing

    // Clock rebuilt from data edges, so it stays locked to the stream
    logic kid_prev_q;
    logic load_clk_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            kid_prev_q <= 1'b0;
            load_clk_q <= 1'b0;
        end else begin
            kid_prev_q <= kid_s;
            if (we_s) begin
                load_clk_q <= 1'b0;
            end else if (kid_s != kid_prev_q) begin
                load_clk_q <= !load_clk_q; // RULE22
            end
        end
    end

    // Loader signals reach only the selected position
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            module_write_enable_n <= 8'hFF;
            module_key_data <= 8'h00;
            module_key_oe <= 8'h00;
            module_load_clk <= 8'h00;
            key_transfer_line_out <= 1'b0;
            key_transfer_line_oe <= 1'b0;
        end else begin
            for (int i = 0; i < cmc_pkg::MODULE_COUNT; i++) begin
                // Unselected modules see idle levels
                module_write_enable_n[i] <= !(loading && enc_index == 3'(i)) || we_s; // RULE21 RULE22
                module_key_data[i] <= (loading && enc_index == 3'(i)) ? kid_s : 1'b0; // RULE21
                module_key_oe[i] <= loading && enc_index == 3'(i) && !we_s; // RULE21
                module_load_clk[i] <= (loading && enc_index == 3'(i)) ? load_clk_q : 1'b0;
            end
            // Selected module's answer goes back when not writing
            key_transfer_line_out <= mkey_s2_q[enc_index]; // RULE21
            key_transfer_line_oe <= loading && we_s; // RULE21
        end
    end

    // Readback pin is synced but not used yet
    logic unused_xfer;
    assign unused_xfer = xfer_in_s;

    ////////////////////////////////////////////////////////////////////////////
    // Alert tone generator

    // Free-running 750 Hz square wave
    localparam int unsigned CNTW = cmc_pkg::CNT_W;
    logic [CNTW-1:0] half_cnt_q;
    logic square_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            half_cnt_q <= '0;
            square_q <= 1'b0;
        end else if (half_cnt_q == CNTW'(cmc_pkg::TONE_HALF_CYC - 1)) begin
            half_cnt_q <= '0;
            square_q <= !square_q; // RULE10
        end else begin
            half_cnt_q <= half_cnt_q + 1'b1;
        end
    end

    // Start-of-activity edges for the single-burst alerts
    logic ptt_clear_q, rx_clear_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ptt_clear_q <= 1'b0;
            rx_clear_q <= 1'b0;
        end else begin
            ptt_clear_q <= activity.ptt_clear;
            rx_clear_q <= activity.rx_clear;
        end
    end

    logic burst_start;
    always_comb begin
        burst_start = 1'b0;
        if (alert_enable[cmc_pkg::AL_CLEAR_TX] && activity.ptt_clear && !ptt_clear_q) begin
            burst_start = 1'b1; // RULE11
        end
        if (alert_enable[cmc_pkg::AL_CLEAR_RX] && activity.rx_clear && !rx_clear_q) begin
            burst_start = 1'b1; // RULE12
        end
        if (alert_enable[cmc_pkg::AL_CROSS] && activity.rx_clear && !rx_clear_q &&
            activity.wireline_coded) begin
            burst_start = 1'b1; // RULE13
        end
    end

    // Conditions for the pulsed key-fail alerts
    logic pulse_req;
    assign pulse_req = (alert_enable[cmc_pkg::AL_TX_FAIL] && activity.ptt_coded
                        && tx_key_fail) // RULE15
                    || (alert_enable[cmc_pkg::AL_RX_FAIL] && activity.rx_coded
                        && rx_key_fail); // RULE16

    // Single burst, or on/off pulsing while a pulse condition holds
    cmc_pkg::cmc_tone_state_type ts_q;
    logic [CNTW-1:0] burst_cnt_q;
    logic burst_done;
    assign burst_done = burst_cnt_q == CNTW'(cmc_pkg::BURST_CYC - 1);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ts_q <= cmc_pkg::TS_IDLE;
            burst_cnt_q <= '0;
        end else begin
            case (ts_q)
                cmc_pkg::TS_IDLE: begin
                    burst_cnt_q <= '0;
                    if (burst_start || pulse_req) begin
                        ts_q <= cmc_pkg::TS_ON;
                    end
                end
                cmc_pkg::TS_ON: begin
                    burst_cnt_q <= burst_done ? '0 : burst_cnt_q + 1'b1;
                    if (burst_done) begin
                        // Pulsed alerts continue with an 87 ms gap
                        ts_q <= pulse_req ? cmc_pkg::TS_OFF : cmc_pkg::TS_IDLE;
                    end
                end
                cmc_pkg::TS_OFF: begin
                    burst_cnt_q <= burst_done ? '0 : burst_cnt_q + 1'b1;
                    if (!pulse_req) begin
                        ts_q <= cmc_pkg::TS_IDLE; // RULE15 RULE16
                        burst_cnt_q <= '0;
                    end else if (burst_done) begin
                        ts_q <= cmc_pkg::TS_ON;
                    end
                end
                default: begin
                    ts_q <= cmc_pkg::TS_IDLE;
                    burst_cnt_q <= '0;
                end
            endcase
        end
    end

    // Tone to wireline and speaker only, never the transmitter
    logic tone_gate;
    assign tone_gate = (ts_q == cmc_pkg::TS_ON)
                    || (alert_enable[cmc_pkg::AL_ERASE] && erase_active); // RULE14
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            alert_tone <= 1'b0;
            tone_to_transmitter <= 1'b0;
        end else begin
            alert_tone <= tone_gate && square_q; // RULE10
            tone_to_transmitter <= 1'b0; // RULE10
        end
    end

endmodule

// ### dv/cmc_top_monitor.sv
// Assertion checker on the cipher module control top ports
`timescale 1ns/1ps
module cmc_top_monitor (
    input wire logic mclk,
    input wire logic resetn,
    input wire cmc_pkg::cmc_select_type ring_select,
    input wire cmc_pkg::cmc_activity_type activity,
    input wire logic [7:0] module_key_n,
    input wire logic loader_present_ground,
    input wire logic external_erase_request_n,
    input wire logic group_a_mode,
    input wire logic group_a_control,
    input wire logic group_b_mode,
    input wire logic group_b_control,
    input wire logic func_select,
    input wire logic [7:0] module_write_enable_n,
    input wire logic [7:0] module_key_data,
    input wire logic [7:0] module_key_oe,
    input wire logic key_erase_n,
    input wire logic access_disable,
    input wire logic [2:0] enc_index,
    input wire logic [2:0] dec_index,
    input wire logic tx_key_fail,
    input wire logic rx_key_fail,
    input wire logic alert_tone,
    input wire logic tone_to_transmitter
);
    // Longest tone high phase, with slack
    localparam int HI_MAX = cmc_pkg::TONE_HALF_CYC + 2;
    logic [2:0] up_q; // Cycles since reset, saturating
    logic [15:0] hi_q; // Length of the current high phase
    logic settled; // Hides reset values from $past
    assign settled = (up_q == 3'h7);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // Settling counter after each reset release
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end
    // Tone high-phase length, saturating
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hi_q <= 16'h0000;
        end else if (!alert_tone) begin
            hi_q <= 16'h0000;
        end else if (hi_q != 16'hFFFF) begin
            hi_q <= hi_q + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_tx_no_tone: assert property (tone_to_transmitter == 1'b0)
        else $error("tone reached the transmitter");
    a_tone_half: assert property (hi_q <= HI_MAX)
        else $error("tone high phase too long");
    a_decrypt_ctl: assert property (
        (group_a_mode -> !group_a_control) && (group_b_mode -> !group_b_control))
        else $error("control high on a decrypting group");
    a_full_modes: assert property (
        settled && $past(ring_select.full_duplex) && !$past(access_disable)
        && !access_disable |-> !group_a_mode && group_b_mode)
        else $error("full duplex modes");
    a_full_pair: assert property (
        settled && $past(ring_select.full_duplex) && !$past(access_disable)
        && !access_disable |-> dec_index == {1'b1, enc_index[1:0]})
        else $error("full duplex pair");
    a_half_same: assert property (
        settled && !$past(ring_select.full_duplex) |-> enc_index == dec_index)
        else $error("half duplex split");
    a_func_follow: assert property (
        settled |-> func_select == $past(ring_select.func_sel))
        else $error("func select lag");
    a_erase_line: assert property (
        (settled && !external_erase_request_n) [*4] |-> !key_erase_n)
        else $error("no erase");
    a_access_in: assert property (
        (settled && !loader_present_ground) [*4] |-> access_disable)
        else $error("access disable missing");
    a_load_onehot: assert property (
        $onehot0(~module_write_enable_n) && $onehot0(module_key_oe)
        && $onehot0(module_key_data)) else $error("loader fan-out");
    a_tx_fail_on: assert property (
        (settled && activity.ptt_coded && !module_key_n[enc_index]) [*6] |-> tx_key_fail)
        else $error("lost key not flagged");
    a_no_fail: assert property (
        (settled && module_key_n == 8'hFF) [*6] |-> !tx_key_fail && !rx_key_fail)
        else $error("false key fail");
    c_full: cover property (settled && ring_select.full_duplex && !group_a_mode);
    c_write: cover property (module_key_oe != 8'h00);
    c_tone: cover property ($rose(alert_tone));
endmodule

bind cmc_top cmc_top_monitor u_mon (.*);

// ### dv/cmc_module_bank.sv
// Behavioural bank of eight plug-in cipher modules on the two group lines
`timescale 1ns/1ps
module cmc_module_bank (
    input wire logic group_a_mode,
    input wire logic group_a_control,
    input wire logic group_b_mode,
    input wire logic group_b_control,
    input wire logic ptt,
    input wire logic [7:0] lost,
    input wire logic [7:0] module_key_oe,
    input wire logic [7:0] module_key_data,
    output logic [7:0] module_key_n,
    output logic [7:0] module_key_in
);
    logic enc_a; // First group set to encrypt
    logic enc_b; // Second group set to encrypt
    // Encrypt is mode low with control high; anything else is not transmit
    assign enc_a = !group_a_mode && group_a_control;
    assign enc_b = !group_b_mode && group_b_control;
    // Key line levels, one module per bit
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // Lost key shows only while keyed up and encrypting
            module_key_n[i] = !(lost[i] && ptt && (i < 4 ? enc_a : enc_b));
            // Module's key line level shows when the device is not driving the line
            module_key_in[i] = module_key_oe[i] ? module_key_data[i] : module_key_n[i];
        end
    end
endmodule

// ### dv/cmc_top_tb_top.sv
// Self-checking testbench for the cipher module control block
`timescale 1ns/1ps
module cmc_top_tb_top;
    localparam int HALF = cmc_pkg::TONE_HALF_CYC;
    logic mclk = 1'b0, resetn, end_of_message_req, loader_present_ground, key_write_enable;
    logic key_insert_serial_data, external_erase_request_n, fw_erase_request;
    logic group_a_mode, group_a_control, group_b_mode, group_b_control, func_select;
    logic key_transfer_line_out, key_transfer_line_oe, key_erase_n, access_disable;
    logic tx_key_fail, rx_key_fail, alert_tone, tone_to_transmitter;
    logic [7:0] module_key_n, module_key_in, module_write_enable_n, module_key_data;
    logic [7:0] module_key_oe, module_load_clk, lost;
    logic [5:0] alert_enable;
    logic [2:0] enc_index, dec_index;
    cmc_pkg::cmc_select_type ring_select;
    cmc_pkg::cmc_activity_type activity;
    int n_fail = 0;
    int tests_run = 0;
    ////////////////////////////////////////////////////////////////////////
    cmc_top uut (.mclk, .resetn, .ring_select, .end_of_message_req, .activity,
        .alert_enable, .module_key_n, .loader_present_ground, .key_write_enable,
        .key_insert_serial_data, .key_transfer_line_in(1'b1), .module_key_in,
        .external_erase_request_n, .fw_erase_request, .group_a_mode, .group_a_control,
        .group_b_mode, .group_b_control, .func_select, .module_write_enable_n,
        .module_key_data, .module_key_oe, .module_load_clk, .key_transfer_line_out,
        .key_transfer_line_oe, .key_erase_n, .access_disable, .enc_index, .dec_index,
        .tx_key_fail, .rx_key_fail, .alert_tone, .tone_to_transmitter);
    cmc_module_bank bank (.group_a_mode, .group_a_control, .group_b_mode,
        .group_b_control, .ptt(activity.ptt_coded || activity.ptt_clear), .lost,
        .module_key_oe, .module_key_data, .module_key_n, .module_key_in);
    // 50 MHz system clock
    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Wait n cycles; ends on a falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Digit map in both duplex modes; digit 0 clamps to module one
    task automatic t_maps();
        for (int d = 0; d <= 8; d++) begin
            ring_select.full_duplex = 1'b0;
            ring_select.key_digit = 4'(d);
            cyc(2);
            chk(enc_index, (d == 0) ? 8'h00 : 8'(d - 1));
            chk({group_a_mode, group_b_mode, group_a_control}, 8'h06);
            ring_select.full_duplex = 1'b1;
            cyc(2);
            chk({dec_index, enc_index}, (d == 0) ? 8'h20 : 8'(32 + 9 * ((d - 1) % 4)));
            chk({group_a_mode, group_a_control, group_b_mode, group_b_control}, 8'h06);
        end
        end_of_message_req = 1'b1;
        cyc(2);
        chk({group_a_control, group_b_control}, 8'h00);
        end_of_message_req = 1'b0;
        ring_select.func_sel = 1'b1;
        cyc(2);
        chk(func_select, 8'h01);
        ring_select.func_sel = 1'b0;
        $display("maps done");
    endtask
    // Coded transmit while the encrypting module loses its key
    task automatic t_key_fail();
        ring_select.key_digit = 4'h3;
        activity.ptt_coded = 1'b1;
        lost = 8'h04;
        cyc(8);
        chk({rx_key_fail, tx_key_fail}, 8'h01);
        lost = 8'h02;
        cyc(8);
        chk({rx_key_fail, tx_key_fail}, 8'h00);
        activity.ptt_coded = 1'b0;
        lost = 8'h00;
        $display("key fail done");
    endtask
    // Loader on a full duplex station still uses the half duplex map
    task automatic t_load();
        ring_select.key_digit = 4'h8;
        loader_present_ground = 1'b0;
        cyc(6);
        chk(access_disable, 8'h01);
        chk({dec_index, enc_index}, 8'h3F);
        key_write_enable = 1'b0;
        cyc(6);
        chk(module_load_clk, 8'h00);
        key_insert_serial_data = 1'b1;
        cyc(6);
        chk(module_write_enable_n, 8'h7F);
        chk(module_key_oe, 8'h80);
        chk(module_key_data, 8'h80);
        chk(module_load_clk, 8'h80);
        key_write_enable = 1'b1;
        cyc(6);
        chk(module_write_enable_n, 8'hFF);
        chk({key_transfer_line_oe, key_transfer_line_out}, 8'h03);
        loader_present_ground = 1'b1;
        cyc(6);
        chk(access_disable, 8'h00);
        $display("key load done");
    endtask
    // Both erase sources drive the shared erase line low
    task automatic t_erase();
        external_erase_request_n = 1'b0;
        cyc(5);
        chk(key_erase_n, 8'h00);
        external_erase_request_n = 1'b1;
        fw_erase_request = 1'b1;
        cyc(3);
        chk(key_erase_n, 8'h00);
        fw_erase_request = 1'b0;
        cyc(5);
        chk(key_erase_n, 8'h01);
        $display("erase done");
    endtask
    // Clear transmit burst: silent when disabled, square wave when enabled
    task automatic t_clear_tx();
        int n;
        activity.ptt_clear = 1'b1;
        repeat (40) begin
            cyc(1);
            chk({tone_to_transmitter, alert_tone}, 8'h00);
        end
        activity.ptt_clear = 1'b0;
        alert_enable[cmc_pkg::AL_CLEAR_TX] = 1'b1;
        cyc(2);
        activity.ptt_clear = 1'b1;
        n = 0;
        while (alert_tone !== 1'b1 && n < HALF + 4) begin
            cyc(1);
            n++;
        end
        chk(alert_tone, 8'h01);
        n = 0;
        while (alert_tone === 1'b1 && n < HALF + 4) begin
            cyc(1);
            n++;
        end
        chk(n >= HALF - 1 && n <= HALF + 1, 8'h01);
        $display("clear tx done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Idle inputs, 12 cycles of reset, then the tests
    initial begin
        resetn = 1'b0;
        ring_select = '0;
        activity = '0;
        alert_enable = 6'h00;
        lost = 8'h00;
        end_of_message_req = 1'b0;
        loader_present_ground = 1'b1;
        key_write_enable = 1'b1;
        key_insert_serial_data = 1'b0;
        external_erase_request_n = 1'b1;
        fw_erase_request = 1'b0;
        cyc(11);
        chk({group_a_mode, group_b_mode, group_a_control, group_b_control, func_select,
            key_erase_n, alert_tone}, 8'h62);
        chk(module_write_enable_n, 8'hFF);
        cyc(1);
        resetn = 1'b1;
        cyc(3);
        t_maps();
        t_key_fail();
        t_load();
        t_erase();
        t_clear_tx();
        summarize();
    end
    // Watchdog sized above the longest tone wait plus the short tests
    initial begin
        repeat (100000) @(posedge mclk);
        n_fail++;
        summarize();
    end
endmodule
